// file: src/brc_top.v
// Purpose: burst read control register and synchronous burst read engine
// Assumes: host clock, enables and address are asynchronous pins
// Notes:   data words come from a user-side stream through a 2-entry buffer
// Operation
// - Burst reads only while enable set
// - Enable clear ignores host clock
// - Sample edge select, falling adds one clock
// - Hold data one or two clocks
// - Exit mode samples address bits 12:11
// - RAM window read clears enable
// - Extra latency bit adds one clock
// - First data after two plus latency
// - Hold keeps each word two clocks
// - Burst length two to length field
// - Bits 6 and 7 read zero
// - Control register at 101C resets zero
`timescale 1ns/1ps
`include "brc_defs.vh"
module brc_top #(
    parameter ADDR_W = 16,
    parameter DATA_W = 16
) (
    // Clock and reset
    input  wire              aclk,
    input  wire              aresetn,
    // AXI4-Lite write
    input  wire [ADDR_W-1:0] s_axi_awaddr,
    input  wire              s_axi_awvalid,
    output reg               s_axi_awready,
    input  wire [31:0]       s_axi_wdata,
    input  wire [3:0]        s_axi_wstrb,
    input  wire              s_axi_wvalid,
    output reg               s_axi_wready,
    output reg  [1:0]        s_axi_bresp,
    output reg               s_axi_bvalid,
    input  wire              s_axi_bready,
    // AXI4-Lite read
    input  wire [ADDR_W-1:0] s_axi_araddr,
    input  wire              s_axi_arvalid,
    output reg               s_axi_arready,
    output reg  [31:0]       s_axi_rdata,
    output reg  [1:0]        s_axi_rresp,
    output reg               s_axi_rvalid,
    input  wire              s_axi_rready,
    // Host pins
    input  wire              host_clk,
    input  wire              host_ce_n,
    input  wire              host_oe_n,
    input  wire [1:0]        host_a_12_11,
    output reg  [DATA_W-1:0] host_d_o,
    output reg               host_d_oe,
    // Data source stream
    input  wire [DATA_W-1:0] src_data,
    input  wire              src_valid,
    output reg               src_ready,
    // Status
    output reg               ram_exit_q,
    output reg               burst_active_q
);
    localparam ST_IDLE = 2'h0;
    localparam ST_LAT  = 2'h1;
    localparam ST_DATA = 2'h2;
    localparam ST_DONE = 2'h3;

    reg  [15:0]       ctrl_q;
    reg  [2:0]        clk_s_q;
    reg  [1:0]        ce_s_q;
    reg  [1:0]        oe_s_q;
    reg  [1:0]        a_s1_q;
    reg  [1:0]        a_s2_q;
    reg  [1:0]        st_q;
    reg  [4:0]        lat_q;
    reg  [10:0]       cnt_q;
    reg               hph_q;
    reg               wr_pend_q;
    reg  [DATA_W-1:0] buf0_q;
    reg  [DATA_W-1:0] buf1_q;
    reg  [1:0]        bcnt_q;
    reg  [ADDR_W-1:0] awa_q;
    reg  [31:0]       wd_q;
    reg  [3:0]        ws_q;
    reg               awh_q;
    reg               wh_q;
    wire              rise = clk_s_q[1] & ~clk_s_q[2];
    wire              fall = ~clk_s_q[1] & clk_s_q[2];
    wire              en = ctrl_q[`BRC_BIT_EN];
    wire              hold = ctrl_q[`BRC_BIT_HOLD];
    wire              inv = ctrl_q[`BRC_BIT_EDGE];
    wire [3:0]        lfld = ctrl_q[`BRC_LEN_HI:`BRC_LEN_LO];
    wire              sel = ~ce_s_q[1] & ~oe_s_q[1];
    wire              pop;
    wire              push = src_valid & src_ready;
    wire              wr_go = (awh_q | s_axi_awvalid) & (wh_q | s_axi_wvalid)
                              & ~s_axi_bvalid & ~wr_pend_q;
    wire [ADDR_W-1:0] wa = awh_q ? awa_q : s_axi_awaddr;
    wire [31:0]       wd = wh_q ? wd_q : s_axi_wdata;
    wire [3:0]        ws = wh_q ? ws_q : s_axi_wstrb;
    wire [15:0]       wm = {{8{ws[1]}}, {8{ws[0]}}} & `BRC_CTRL_WMASK;
    wire              wr_hit = wr_go & (wa == `BRC_CTRL_ADDR);
    wire              ram_hit;
    wire [4:0]        first = `BRC_LAT_BASE
                              + {1'b0, ctrl_q[`BRC_LAT_HI:`BRC_LAT_LO]}
                              + {4'h0, ctrl_q[`BRC_BIT_XLAT]};
    wire [3:0]        lexp = (hold && lfld != 4'h0) ? lfld - 4'h1 : lfld;
    wire [10:0]       words = 11'h001 << lexp;

    assign ram_hit = ctrl_q[`BRC_BIT_EXIT] && a_s2_q == `BRC_RAM_WIN;
    assign pop = (st_q == ST_DATA) && rise && !hph_q && bcnt_q != 2'h0;

    // Pin synchronisers; first stage feeds only the second
    always @(posedge aclk) begin
        if (!aresetn) begin
            clk_s_q <= 3'h0;
            ce_s_q  <= 2'h3;
            oe_s_q  <= 2'h3;
            a_s1_q  <= 2'h0;
            a_s2_q  <= 2'h0;
        end else begin
            clk_s_q <= en ? {clk_s_q[1:0], host_clk} : 3'h0;
            ce_s_q  <= {ce_s_q[0], host_ce_n};
            oe_s_q  <= {oe_s_q[0], host_oe_n};
            a_s1_q  <= host_a_12_11;
            a_s2_q  <= a_s1_q;
        end
    end

    // AXI4-Lite slave
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= `BRC_RESP_OKAY;
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rresp   <= `BRC_RESP_OKAY;
            s_axi_rdata   <= 32'h0000_0000;
            awh_q         <= 1'b0;
            wh_q          <= 1'b0;
            awa_q         <= {ADDR_W{1'b0}};
            wr_pend_q     <= 1'b0;
            wd_q          <= 32'h0000_0000;
            ws_q          <= 4'h0;
            ctrl_q        <= `BRC_CTRL_RESET;
        end else begin
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_arready <= 1'b0;
            if (s_axi_awvalid && !awh_q && !s_axi_awready && !wr_go) begin
                awh_q         <= 1'b1;
                awa_q         <= s_axi_awaddr;
                s_axi_awready <= 1'b1;
            end
            if (s_axi_wvalid && !wh_q && !s_axi_wready && !wr_go) begin
                wh_q         <= 1'b1;
                wd_q         <= s_axi_wdata;
                ws_q         <= s_axi_wstrb;
                s_axi_wready <= 1'b1;
            end
            wr_pend_q <= wr_go;
            if (wr_go) begin
                s_axi_awready <= ~awh_q;
                s_axi_wready  <= ~wh_q;
                awh_q         <= 1'b0;
                wh_q          <= 1'b0;
                s_axi_bresp   <= wr_hit ? `BRC_RESP_OKAY : `BRC_RESP_SLVERR;
            end
            // Response only after both channels are taken
            if (wr_pend_q) begin
                s_axi_bvalid <= 1'b1;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
            if (wr_hit) begin
                ctrl_q <= (ctrl_q & ~wm) | (wd[15:0] & wm);
            end
            if (st_q == ST_IDLE && en && sel && ram_hit) begin
                ctrl_q[`BRC_BIT_EN] <= 1'b0;
            end
            if (s_axi_arvalid && !s_axi_rvalid && !s_axi_arready) begin
                s_axi_arready <= 1'b1;
                if (s_axi_araddr == `BRC_CTRL_ADDR) begin
                    s_axi_rdata <= {16'h0000, ctrl_q};
                    s_axi_rresp <= `BRC_RESP_OKAY;
                end else begin
                    s_axi_rdata <= 32'h0000_0000;
                    s_axi_rresp <= `BRC_RESP_SLVERR;
                end
            end
            // Read data follows the address handshake
            if (s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // Two-entry buffer; buf0 is the head
    always @(posedge aclk) begin
        if (!aresetn) begin
            buf0_q    <= {DATA_W{1'b0}};
            buf1_q    <= {DATA_W{1'b0}};
            bcnt_q    <= 2'h0;
            src_ready <= 1'b0;
        end else begin
            case ({push, pop})
                2'b10: begin
                    if (bcnt_q == 2'h0) begin
                        buf0_q <= src_data;
                    end else begin
                        buf1_q <= src_data;
                    end
                    bcnt_q <= bcnt_q + 2'h1;
                end
                2'b01: begin
                    buf0_q <= buf1_q;
                    bcnt_q <= bcnt_q - 2'h1;
                end
                2'b11: begin
                    buf0_q <= (bcnt_q == 2'h1) ? src_data : buf1_q;
                    buf1_q <= src_data;
                end
                default: begin
                    bcnt_q <= bcnt_q;
                end
            endcase
            src_ready <= (bcnt_q + {1'b0, push} - {1'b0, pop}) < 2'h2;
        end
    end

    // Burst engine
    always @(posedge aclk) begin
        if (!aresetn) begin
            st_q           <= ST_IDLE;
            lat_q          <= 5'h00;
            cnt_q          <= 11'h000;
            hph_q          <= 1'b0;
            host_d_o       <= {DATA_W{1'b0}};
            host_d_oe      <= 1'b0;
            ram_exit_q     <= 1'b0;
            burst_active_q <= 1'b0;
        end else begin
            ram_exit_q <= ram_exit_q & sel;
            case (st_q)
                ST_IDLE: begin
                    host_d_oe <= 1'b0;
                    if (en && sel && ram_hit) begin
                        ram_exit_q <= 1'b1;
                    end else if (en && sel && (inv ? fall : rise)) begin
                        st_q   <= ST_LAT;
                        // first data count, falling adds one
                        lat_q  <= inv ? first : first - 5'h01;
                        cnt_q  <= words;
                        hph_q  <= 1'b0;
                        burst_active_q <= 1'b1;
                    end
                end
                ST_LAT: begin
                    if (rise) begin
                        if (lat_q == 5'h01) begin
                            st_q <= ST_DATA;
                        end
                        lat_q <= lat_q - 5'h01;
                    end
                end
                ST_DATA: begin
                    if (pop) begin
                        host_d_o  <= buf0_q;
                        host_d_oe <= 1'b1;
                        hph_q     <= hold;
                        cnt_q     <= cnt_q - 11'h001;
                        if (cnt_q == 11'h001) begin
                            st_q <= ST_DONE;
                        end
                    end else if (rise) begin
                        hph_q <= 1'b0;
                    end
                end
                ST_DONE: begin
                    if (!sel) begin
                        st_q           <= ST_IDLE;
                        host_d_oe      <= 1'b0;
                        burst_active_q <= 1'b0;
                    end
                end
                default: begin
                    st_q <= ST_IDLE;
                end
            endcase
            if (st_q != ST_IDLE && !sel) begin
                st_q           <= ST_IDLE;
                host_d_oe      <= 1'b0;
                burst_active_q <= 1'b0;
            end
        end
    end
endmodule // brc_top

// file: src/brc_defs.vh
// Purpose: constants for the synchronous burst read control block
// Assumes: AXI4-Lite byte addressing, 32-bit data
// Notes:   definitions only
`ifndef BRC_DEFS_VH
`define BRC_DEFS_VH
`define BRC_CTRL_ADDR      16'h101C
`define BRC_CTRL_RESET     16'h0000
`define BRC_CTRL_WMASK     16'hFF3F
`define BRC_BIT_EN         0
`define BRC_BIT_EDGE       1
`define BRC_BIT_HOLD       2
`define BRC_BIT_FIFO       3
`define BRC_BIT_EXIT       4
`define BRC_BIT_XLAT       5
`define BRC_LAT_LO         8
`define BRC_LAT_HI         11
`define BRC_LEN_LO         12
`define BRC_LEN_HI         15
`define BRC_LAT_BASE       5'h02
`define BRC_RAM_WIN        2'h3
`define BRC_RESP_OKAY      2'h0
`define BRC_RESP_SLVERR    2'h2
`endif

// file: tb/brc_top_asserts.sv
// Purpose: port-level checks for the burst read control block
// Assumes: one aclk domain, synchronous active-low reset
// Notes:   bound to brc_top
`timescale 1ns/1ps
module brc_top_asserts #(
    parameter DATA_W = 16
) (
    // Clock and reset
    input wire              aclk,
    input wire              aresetn,
    // Register bus
    input wire              s_axi_awvalid,
    input wire              s_axi_awready,
    input wire              s_axi_wvalid,
    input wire              s_axi_wready,
    input wire              s_axi_bvalid,
    input wire              s_axi_arvalid,
    input wire              s_axi_arready,
    input wire              s_axi_rvalid,
    input wire [31:0]       s_axi_rdata,
    // Host pins and status
    input wire              host_clk,
    input wire              host_ce_n,
    input wire [DATA_W-1:0] host_d_o,
    input wire              host_d_oe,
    input wire              src_ready,
    input wire              ram_exit_q,
    input wire              burst_active_q
);
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    reset_idle_a: assert property ($rose(aresetn) |->
        !s_axi_bvalid && !s_axi_rvalid && !host_d_oe && !src_ready)
        else $error("outputs not idle after reset");
    write_answer_a: assert property (s_axi_awvalid && s_axi_wvalid &&
        !s_axi_bvalid && !s_axi_awready && !s_axi_wready
        |=> s_axi_awready && s_axi_wready ##1 s_axi_bvalid)
        else $error("write not answered in time");
    read_answer_a: assert property (s_axi_arvalid && !s_axi_rvalid
        && !s_axi_arready |=> s_axi_arready ##1 s_axi_rvalid)
        else $error("read not answered in time");
    read_zero_a: assert property (s_axi_rvalid |->
        s_axi_rdata[31:16] == 16'h0000 && s_axi_rdata[7:6] == 2'h0)
        else $error("reserved read bits not zero");
    idle_quiet_a: assert property (host_ce_n [*6] |=>
        !host_d_oe && !burst_active_q)
        else $error("burst outlives chip enable");
    exit_quiet_a: assert property (ram_exit_q |-> !host_d_oe)
        else $error("data driven during window exit");
    exit_release_a: assert property (host_ce_n [*6] |=> !ram_exit_q)
        else $error("exit flag held without enables");
    data_on_edge_a: assert property (host_d_oe && $past(host_d_oe) &&
        $changed(host_d_o) |-> $past(host_clk) != $past(host_clk, 8))
        else $error("data changed without host clock edge");
endmodule // brc_top_asserts
bind brc_top brc_top_asserts #(.DATA_W(DATA_W)) u_brc_chk (
    .aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rvalid, .s_axi_rdata, .host_clk, .host_ce_n, .host_d_o,
    .host_d_oe, .src_ready, .ram_exit_q, .burst_active_q);

// file: tb/brc_host_model.sv
// Purpose: host model issuing synchronous burst reads
// Assumes: host clock runs only inside a frame, 160 ns period
// Notes:   words are latched at each falling host clock edge
`timescale 1ns/1ps
module brc_host_model (
    // Bench clock
    input  wire         aclk,
    // Host pins
    output logic        host_clk,
    output logic        host_ce_n,
    output logic        host_oe_n,
    output logic [1:0]  host_a_12_11,
    input  wire  [15:0] host_d_o,
    input  wire         host_d_oe
);
    logic [15:0] got [$];
    int          first_idx;
    initial begin
        host_clk = 1'b0;
        host_ce_n = 1'b1;
        host_oe_n = 1'b1;
        host_a_12_11 = 2'h0;
    end
    task automatic frame(input int rises, input logic [1:0] a);
        got.delete();
        first_idx = -1;
        host_ce_n <= 1'b0;
        host_oe_n <= 1'b0;
        host_a_12_11 <= a;
        for (int r = 1; r <= rises; r++) begin
            repeat (20) @(posedge aclk);
            host_clk <= 1'b1;
            repeat (20) @(posedge aclk);
            host_clk <= 1'b0;
            if (host_d_oe === 1'b1 && first_idx < 0)
                first_idx = r;
            if (host_d_oe === 1'b1)
                got.push_back(host_d_o);
        end
        repeat (20) @(posedge aclk);
        host_ce_n <= 1'b1;
        host_oe_n <= 1'b1;
        host_a_12_11 <= ~a;
    endtask
endmodule // brc_host_model

// file: tb/burst_read_control_test.sv
// Purpose: self-checking bench for the burst read control block
// Assumes: source words count up from A000
// Notes:   register access over AXI4-Lite
`timescale 1ns/1ps
`include "brc_defs.vh"
module burst_read_control_test;
    logic        aclk = 0;
    logic        aresetn = 0;
    logic [15:0] awaddr = 0;
    logic [15:0] araddr = 0;
    logic [15:0] src_data = 16'hA000;
    logic [31:0] wdata = 0;
    logic [31:0] rdata, rd;
    logic        awvalid = 0, wvalid = 0, bready = 0, saw_exit = 0;
    logic        saw_act = 0;
    logic        arvalid = 0, rready = 0, src_valid = 0;
    logic        awready, wready, bvalid, arready, rvalid, src_ready;
    logic [1:0]  bresp, rresp, rsp, a_hi;
    logic        hclk, ce_n, oe_n, d_oe, ram_exit_q, burst_active_q;
    logic [15:0] d_o;
    int          fails = 0, tests_run = 0, used = 0;
    // none sets FIFO with hold, lengths stay small
    logic [15:0] cfg [4] = '{16'h2111, 16'h2005, 16'h0021, 16'h1003};
    brc_top DUT (.aclk, .aresetn, .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .host_clk(hclk), .host_ce_n(ce_n),
        .host_oe_n(oe_n), .host_a_12_11(a_hi), .host_d_o(d_o),
        .host_d_oe(d_oe), .src_data, .src_valid, .src_ready,
        .ram_exit_q, .burst_active_q);
    brc_host_model host (.aclk, .host_clk(hclk), .host_ce_n(ce_n),
        .host_oe_n(oe_n), .host_a_12_11(a_hi), .host_d_o(d_o),
        .host_d_oe(d_oe));
    initial forever #2 aclk = ~aclk;
    always @(posedge aclk) begin
        if (src_valid && src_ready)
            src_data <= src_data + 16'h0001;
        if (ram_exit_q)
            saw_exit <= 1'b1;
        if (burst_active_q)
            saw_act <= 1'b1;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            fails++;
            $display("wrong value at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic summarize;
        $display("checks %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic guard(input int n);
        if (n >= 100) begin
            fails++;
            summarize();
        end
    endtask
    task automatic wr(input logic [15:0] a, input logic [31:0] d);
        int n;
        n = 0;
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            n++;
        end while (!bvalid && n < 100);
        guard(n);
        rsp = bresp;
        bready <= 1'b0;
        @(posedge aclk);
    endtask
    task automatic rd_reg(input logic [15:0] a);
        int n;
        n = 0;
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
            n++;
        end while (!rvalid && n < 100);
        guard(n);
        rd = rdata;
        rsp = rresp;
        rready <= 1'b0;
        @(posedge aclk);
    endtask
    initial begin
        logic [15:0] c;
        int w, k;
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        rd_reg(`BRC_CTRL_ADDR);
        chk(rd, 32'h0);
        rd_reg(16'h1020);
        chk(rsp, `BRC_RESP_SLVERR);
        wr(16'h1020, 32'h0000FFFF);
        chk(rsp, `BRC_RESP_SLVERR);
        wr(`BRC_CTRL_ADDR, 32'hFFFFA5C2);
        rd_reg(`BRC_CTRL_ADDR);
        chk(rd, 32'h0000A502);
        src_valid <= 1'b1;
        wr(`BRC_CTRL_ADDR, 32'h00002100);
        repeat (10) @(posedge aclk);
        chk(src_ready, 1'b0);
        host.frame(8, 2'h0);
        chk(host.got.size(), 0);
        foreach (cfg[i]) begin
            c = cfg[i];
            w = c[2] ? 1 << (c[15:12] - 1) : 1 << c[15:12];
            wr(`BRC_CTRL_ADDR, {16'h0000, c});
            k = 3 + c[11:8] + c[5];
            host.frame(k - 1 + w * (c[2] + 1) + c[1], 2'h0);
            chk(host.got.size(), w * (c[2] + 1));
            if (!c[1]) chk(host.first_idx, k);
            foreach (host.got[j])
                chk(host.got[j], 16'hA000 + used + (j >> c[2]));
            used += w;
        end
        chk(saw_act, 1'b1);
        wr(`BRC_CTRL_ADDR, 32'h00000011);
        host.frame(6, 2'h3);
        chk(saw_exit, 1'b1);
        chk(host.got.size(), 0);
        rd_reg(`BRC_CTRL_ADDR);
        chk(rd, 32'h00000010);
        summarize();
    end
endmodule // burst_read_control_test
